// ==== inc/serial_flash_regs.svh ====
// Constants of the serial flash read path: command codes, phase lengths, array size.
// Included by both ends and by the bench; holds definitions only.
//
// Overview of operation
// [RULE1] Host uses fast read above slow limit
// [RULE2] Eight command bits on SI, MSB first
// [RULE3] Then 24 address bits, A23 first
// [RULE4] Fast read adds dummy byte; slow none
// [RULE5] Single read: SO, one bit per clock
// [RULE6] Address counter advances after each byte
// [RULE7] Last location wraps to zero, no delay
// [RULE8] Select high ends read, SO released
// [RULE9] Dual read: dummy byte, SI becomes output
// [RULE10] Dual: four clocks, bits 7,6 first
// [RULE11] Dual end releases SO and SI
// [RULE12] Quad read needs quad enable bit
// [RULE13] Quad: dummy, then HOLD, WP, SI outputs
// [RULE14] Quad: two clocks, 7..4 then 3..0
// [RULE15] Quad end releases all four lines
// [RULE16] Host sets byte count by select length
// [RULE17] Format counts lines: command, address, data
// [RULE18] New select returns lines to input roles
// [RULE19] Quad read ignored when quad disabled
`ifndef SERIAL_FLASH_REGS_SVH
`define SERIAL_FLASH_REGS_SVH

`define CMD_READ_SLOW 8'h03
`define CMD_READ_FAST 8'h0b
`define CMD_READ_DUAL 8'h3b
`define CMD_READ_QUAD 8'h6b

`define CMD_BITS 6'h08
`define ADDR_BITS 6'h18
`define DUMMY_BITS 6'h08

`define ARRAY_ADDR_W 18
`define CLK_HZ 25000000
`define SCK_HALF_DIV 8

`endif

// ==== inc/serial_flash_pkg.sv ====
// Types shared by both ends of the serial flash read path.
// Needs nothing else compiled before it.
package serial_flash_pkg;

    // Data lanes used in the data phase (1-1-1, 1-1-2, 1-1-4)
    typedef enum logic [1:0] {LANES_1, LANES_2, LANES_4} lanes_e;

    typedef enum logic [2:0] {D_CMD, D_ADDR, D_DUMMY, D_DATA, D_IGNORE} dev_state_e;

    typedef enum logic [2:0] {H_IDLE, H_SHIFT, H_DATA, H_END} host_state_e;

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic sck_s1;
        logic sck_s2;
        logic sck_s3;
        logic [3:0] io_s1;
        logic [3:0] io_s2;
        dev_state_e st;
        lanes_e lanes;
        logic [5:0] cnt;
        logic [23:0] sh;
        logic [7:0] cmd;
        logic [23:0] addr;
        logic [7:0] byte_sh;
        logic [2:0] beat;
        logic [3:0] io_out;
        logic [3:0] io_oe;
    } dev_s;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic [15:0] tmr;
        logic [3:0] io_s1;
        logic [3:0] io_s2;
        host_state_e st;
        lanes_e lanes;
        logic [39:0] tx;
        logic [5:0] bits;
        logic [7:0] rx;
        logic [2:0] beat;
        logic [23:0] left;
        logic si_out;
        logic si_oe;
        logic busy;
        logic [7:0] rx_data;
        logic rx_valid;
    } host_s;

endpackage

// ==== inc/spi_link_if.sv ====
// Serial link between host controller and flash device.
// io[0]=SI, io[1]=SO, io[2]=WP, io[3]=HOLD; undriven lines read as pulled up.
`timescale 1ns/1ps
`default_nettype none

interface spi_link_if;
    logic cs_n;
    logic sck;
    logic [3:0] dev_out;
    logic [3:0] dev_oe;
    logic [3:0] host_out;
    logic [3:0] host_oe;
    wire logic [3:0] io;

    // Resolve each data line from the two enables, pull-up when idle
    for (genvar i = 0; i < 4; i++) begin : g_line
        assign io[i] = dev_oe[i] ? dev_out[i] : (host_oe[i] ? host_out[i] : 1'b1);
    end

    modport dev (input cs_n, input sck, input io, output dev_out, output dev_oe);
    modport host (output cs_n, output sck, output host_out, output host_oe, input io);
endinterface

`default_nettype wire

// ==== rtl/serial_flash_dev.sv ====
// Flash device end: takes a read command and address on SI, then streams the
// array on one, two or four lines while the host keeps clocking.
// Assumes the serial clock is slow enough that clk sees every level for at
// least three cycles; all link inputs pass two flip-flops first.
`timescale 1ns/1ps
`default_nettype none
`include "serial_flash_regs.svh"

module serial_flash_dev
    import serial_flash_pkg::*;
#(
    parameter int ADDR_W = `ARRAY_ADDR_W
) (
    input wire logic clk,
    input wire logic srst,
    spi_link_if.dev link,
    input wire logic quad_enable_bit,
    input wire logic mem_wr_en,
    input wire logic [23:0] mem_wr_addr,
    input wire logic [7:0] mem_wr_data
);

    localparam int DEPTH = 1 << ADDR_W;
    localparam logic [23:0] ADDR_MASK = 24'((64'h1 << ADDR_W) - 64'h1);

    // Array contents; loaded through the user-side write port
    logic [7:0] mem [DEPTH];

    dev_s q;
    dev_s d;
    logic rise;
    logic fall;
    logic si;
    logic [7:0] rd_byte;
    logic [7:0] cur;
    logic [7:0] cmd_next;
    logic [23:0] addr_next;
    logic cmd_known;

    // Preload port for the array
    always_ff @(posedge clk) begin
        if (mem_wr_en) begin
            mem[mem_wr_addr[ADDR_W-1:0]] <= mem_wr_data;
        end
    end

    // Edge detection on the synchronised serial clock
    assign rise = q.sck_s2 & ~q.sck_s3;
    assign fall = ~q.sck_s2 & q.sck_s3;
    assign si = q.io_s2[0];
    assign rd_byte = mem[q.addr[ADDR_W-1:0]];
    assign cmd_next = {q.sh[6:0], si};
    assign addr_next = {q.sh[22:0], si} & ADDR_MASK;

    // Commands this block answers; quad only with the enable bit set
    always_comb begin
        case (cmd_next)
            `CMD_READ_SLOW: cmd_known = 1'b1;
            `CMD_READ_FAST: cmd_known = 1'b1;
            `CMD_READ_DUAL: cmd_known = 1'b1;
            `CMD_READ_QUAD: cmd_known = quad_enable_bit; // see [RULE12] see [RULE19]
            default: cmd_known = 1'b0;
        endcase
    end

    // Next state of the whole device end
    always_comb begin
        d = q;
        cur = 8'h00;

        // Two-stage synchronisers on every link input
        d.cs_s1 = link.cs_n;
        d.cs_s2 = q.cs_s1;
        d.sck_s1 = link.sck;
        d.sck_s2 = q.sck_s1;
        d.sck_s3 = q.sck_s2;
        d.io_s1 = link.io;
        d.io_s2 = q.io_s1;

        if (q.cs_s2) begin
            // Deselected: release all lines and wait for a new command
            d.st = D_CMD; // see [RULE18]
            d.cnt = 6'h00;
            d.beat = 3'h0;
            d.io_oe = 4'h0; // see [RULE8] see [RULE11] see [RULE15]
            d.io_out = 4'h0;
        end else begin
            case (q.st)
                D_CMD: begin
                    // Eight command bits, MSB first, on SI
                    if (rise) begin
                        d.sh = {q.sh[22:0], si}; // see [RULE2]
                        d.cnt = q.cnt + 6'h01;
                        if (q.cnt == `CMD_BITS - 6'h01) begin
                            d.cmd = cmd_next;
                            d.cnt = 6'h00;
                            if (cmd_known) begin
                                d.st = D_ADDR;
                            end else begin
                                d.st = D_IGNORE; // see [RULE19]
                            end
                            case (cmd_next)
                                `CMD_READ_DUAL: d.lanes = LANES_2;
                                `CMD_READ_QUAD: d.lanes = LANES_4;
                                default: d.lanes = LANES_1;
                            endcase
                        end
                    end
                end

                D_ADDR: begin
                    // 24 address bits, A23 first
                    if (rise) begin
                        d.sh = {q.sh[22:0], si}; // see [RULE3]
                        d.cnt = q.cnt + 6'h01;
                        if (q.cnt == `ADDR_BITS - 6'h01) begin
                            d.addr = addr_next;
                            d.cnt = 6'h00;
                            d.beat = 3'h0;
                            if (q.cmd == `CMD_READ_SLOW) begin
                                d.st = D_DATA; // see [RULE4]
                            end else begin
                                d.st = D_DUMMY; // see [RULE4] see [RULE9] see [RULE13]
                            end
                        end
                    end
                end

                D_DUMMY: begin
                    // Dummy byte is clocked in and discarded
                    if (rise) begin
                        d.cnt = q.cnt + 6'h01;
                        if (q.cnt == `DUMMY_BITS - 6'h01) begin
                            d.cnt = 6'h00;
                            d.st = D_DATA;
                        end
                    end
                end

                D_DATA: begin
                    // Data changes on the falling edge so it is stable at the rise
                    if (fall) begin
                        if (q.beat == 3'h0) begin
                            // Fetch next byte and advance the counter, wrapping at the top
                            cur = rd_byte;
                            d.addr = (q.addr + 24'h000001) & ADDR_MASK; // see [RULE6] see [RULE7]
                        end else begin
                            cur = q.byte_sh;
                        end
                        case (q.lanes)
                            LANES_2: begin
                                // SO carries the higher bit, SI the lower
                                d.io_out = {2'b00, cur[7], cur[6]}; // see [RULE10]
                                d.io_oe = 4'h3; // see [RULE9]
                                d.byte_sh = {cur[5:0], 2'b00};
                                d.beat = (q.beat == 3'h0) ? 3'h3 : q.beat - 3'h1;
                            end
                            LANES_4: begin
                                // HOLD, WP, SO, SI carry a nibble
                                d.io_out = cur[7:4]; // see [RULE14]
                                d.io_oe = 4'hf; // see [RULE13]
                                d.byte_sh = {cur[3:0], 4'h0};
                                d.beat = (q.beat == 3'h0) ? 3'h1 : q.beat - 3'h1;
                            end
                            default: begin
                                // Single line: SO only
                                d.io_out = {2'b00, cur[7], 1'b0}; // see [RULE5]
                                d.io_oe = 4'h2;
                                d.byte_sh = {cur[6:0], 1'b0};
                                d.beat = (q.beat == 3'h0) ? 3'h7 : q.beat - 3'h1;
                            end
                        endcase
                    end
                end

                D_IGNORE: begin
                    // Unsupported command: stay off the lines until deselect
                    d.io_oe = 4'h0;
                end

                default: begin
                    d.st = D_CMD;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '{
                cs_s1: 1'b1,
                cs_s2: 1'b1,
                sck_s1: 1'b0,
                sck_s2: 1'b0,
                sck_s3: 1'b0,
                io_s1: 4'h0,
                io_s2: 4'h0,
                st: D_CMD,
                lanes: LANES_1,
                cnt: 6'h00,
                sh: 24'h000000,
                cmd: 8'h00,
                addr: 24'h000000,
                byte_sh: 8'h00,
                beat: 3'h0,
                io_out: 4'h0,
                io_oe: 4'h0
            };
        end else begin
            q <= d;
        end
    end

    // Line drivers straight from flops
    assign link.dev_out = q.io_out;
    assign link.dev_oe = q.io_oe;

endmodule

`default_nettype wire

// ==== rtl/serial_flash_host.sv ====
// Host controller end: frames one read with select, makes the serial clock
// by dividing clk, shifts out command, address and, except for slow read, dummy, collects data bytes.
// Assumes the device answers within a few clk cycles of each falling edge.
`timescale 1ns/1ps
`default_nettype none
`include "serial_flash_regs.svh"

module serial_flash_host
    import serial_flash_pkg::*;
#(
    parameter int CLK_HZ = `CLK_HZ,
    parameter int HALF_DIV = `SCK_HALF_DIV,
    parameter int LOW_FREQ_LIMIT_HZ = 50000000
) (
    input wire logic clk,
    input wire logic srst,
    spi_link_if.host link,
    input wire logic start,
    input wire logic [7:0] cmd,
    input wire logic [23:0] addr,
    input wire logic [23:0] nbytes,
    output logic busy,
    output logic [7:0] rx_data,
    output logic rx_valid
);

    localparam int SCK_HZ = CLK_HZ / (2 * HALF_DIV);
    localparam bit SLOW_OK = (SCK_HZ <= LOW_FREQ_LIMIT_HZ);

    host_s q;
    host_s d;
    logic tick;
    logic samp;
    logic [7:0] cmd_eff;
    logic [7:0] rx_next;
    logic [2:0] beats;

    // Half-period tick, and a sample point just before the falling edge
    assign tick = (q.tmr == 16'(HALF_DIV - 1));
    assign samp = q.sck && (q.tmr == 16'(HALF_DIV - 2));

    // Slow read only at or under the low-frequency limit
    assign cmd_eff = (cmd == `CMD_READ_SLOW && !SLOW_OK) ? `CMD_READ_FAST : cmd; // see [RULE1]

    // Gather one beat of data from the lanes in use
    always_comb begin
        case (q.lanes)
            LANES_2: begin
                rx_next = {q.rx[5:0], q.io_s2[1], q.io_s2[0]};
                beats = 3'h3;
            end
            LANES_4: begin
                rx_next = {q.rx[3:0], q.io_s2};
                beats = 3'h1;
            end
            default: begin
                rx_next = {q.rx[6:0], q.io_s2[1]};
                beats = 3'h7;
            end
        endcase
    end

    // Next state of the host end
    always_comb begin
        d = q;
        d.io_s1 = link.io;
        d.io_s2 = q.io_s1;
        d.rx_valid = 1'b0;
        d.tmr = (tick || !q.busy) ? 16'h0000 : q.tmr + 16'h0001;
        case (q.st)
            H_IDLE: begin
                if (start) begin
                    // Select, then command, address and optional dummy on SI
                    d.cs_n = 1'b0;
                    d.sck = 1'b0;
                    d.busy = 1'b1;
                    d.tx = {cmd_eff, addr, 8'h00}; // see [RULE2] see [RULE3]
                    d.bits = (cmd_eff == `CMD_READ_SLOW) ? 6'h20 : 6'h28; // see [RULE4] see [RULE9]
                    d.si_out = cmd_eff[7];
                    d.si_oe = 1'b1;
                    d.left = (nbytes == 24'h000000) ? 24'h000001 : nbytes; // see [RULE16]
                    d.rx = 8'h00;
                    d.st = H_SHIFT;
                    case (cmd_eff)
                        `CMD_READ_DUAL: d.lanes = LANES_2; // see [RULE17]
                        `CMD_READ_QUAD: d.lanes = LANES_4;
                        default: d.lanes = LANES_1;
                    endcase
                end
            end
            H_SHIFT: begin
                if (tick) begin
                    d.sck = ~q.sck;
                    if (!q.sck) begin
                        d.bits = q.bits - 6'h01;
                    end else if (q.bits == 6'h00) begin
                        // Release SI so the device may turn it round
                        d.si_oe = 1'b0; // see [RULE9] see [RULE13]
                        d.beat = beats;
                        d.st = H_DATA;
                    end else begin
                        d.tx = {q.tx[38:0], 1'b0};
                        d.si_out = q.tx[38];
                    end
                end
            end
            H_DATA: begin
                if (tick) begin
                    d.sck = ~q.sck;
                end
                if (samp) begin
                    d.rx = rx_next;
                    d.beat = q.beat - 3'h1;
                    if (q.beat == 3'h0) begin
                        d.rx_data = rx_next;
                        d.rx_valid = 1'b1;
                        d.beat = beats;
                        d.left = q.left - 24'h000001;
                        if (q.left == 24'h000001) begin
                            d.st = H_END;
                        end
                    end
                end
            end
            H_END: begin
                // Finish the clock low, then deselect half a period later
                if (tick) begin
                    if (q.sck) begin
                        d.sck = 1'b0;
                    end else begin
                        d.cs_n = 1'b1; // see [RULE8] see [RULE16]
                        d.busy = 1'b0;
                        d.st = H_IDLE;
                    end
                end
            end
            default: begin
                d.st = H_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '{
                cs_n: 1'b1,
                sck: 1'b0,
                tmr: 16'h0000,
                io_s1: 4'h0,
                io_s2: 4'h0,
                st: H_IDLE,
                lanes: LANES_1,
                tx: 40'h0000000000,
                bits: 6'h00,
                rx: 8'h00,
                beat: 3'h0,
                left: 24'h000000,
                si_out: 1'b0,
                si_oe: 1'b0,
                busy: 1'b0,
                rx_data: 8'h00,
                rx_valid: 1'b0
            };
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign link.cs_n = q.cs_n;
    assign link.sck = q.sck;
    assign link.host_out = {3'b000, q.si_out};
    assign link.host_oe = {3'b000, q.si_oe};
    assign busy = q.busy;
    assign rx_data = q.rx_data;
    assign rx_valid = q.rx_valid;

endmodule

`default_nettype wire

// ==== dv/serial_flash_sva.sv ====
// Checker for the serial link between the flash host and the flash device.
// Takes the link interface's signals as plain inputs; instantiated beside the interface.
`timescale 1ns/1ps
`default_nettype none
`include "serial_flash_regs.svh"

module serial_flash_sva
    import serial_flash_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic [3:0] io,
    input wire logic [3:0] dev_out,
    input wire logic [3:0] dev_oe,
    input wire logic [3:0] host_out,
    input wire logic [3:0] host_oe
);
    logic sck_q;
    logic [5:0] rise_q;
    logic [7:0] cmd_q;
    logic [3:0] fall_age_q;
    logic [3:0] lanes_exp;

    // Frame bookkeeping: rising edges seen, command byte, cycles since sck fell
    always_ff @(posedge clk) begin
        sck_q <= sck;
        if (srst || cs_n) begin
            rise_q <= 6'h00;
            cmd_q <= 8'h00;
        end else if (sck && !sck_q && rise_q != 6'h3f) begin
            rise_q <= rise_q + 6'h01;
            if (rise_q < 6'h08) cmd_q <= {cmd_q[6:0], io[0]};
        end
        if (srst) fall_age_q <= 4'hf;
        else if (!sck && sck_q) fall_age_q <= 4'h0;
        else if (fall_age_q != 4'hf) fall_age_q <= fall_age_q + 4'h1;
    end

    // Lines the device may drive for the decoded command
    assign lanes_exp = (cmd_q == `CMD_READ_DUAL) ? 4'h3 :
        ((cmd_q == `CMD_READ_QUAD) ? 4'hf : 4'h2);

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_select;
        $fell(cs_n);
    endsequence
    sequence s_deselected;
        cs_n [*8];
    endsequence

    property p_release_on_deselect;
        $rose(cs_n) |-> ##[1:6] (dev_oe == 4'h0);
    endproperty
    a_release_on_deselect: assert property (p_release_on_deselect)
        else $error("device still drives after deselect");

    property p_quiet_when_deselected;
        s_deselected |-> (dev_oe == 4'h0);
    endproperty
    a_quiet_when_deselected: assert property (p_quiet_when_deselected)
        else $error("device drives while deselected");

    property p_input_roles_at_select;
        s_select |-> (dev_oe == 4'h0) [*8];
    endproperty
    a_input_roles_at_select: assert property (p_input_roles_at_select)
        else $error("device drives at start of frame");

    property p_host_drives_cmd;
        s_select |-> host_oe[0] [*8];
    endproperty
    a_host_drives_cmd: assert property (p_host_drives_cmd)
        else $error("host not driving command line");

    property p_no_data_before_address;
        (!cs_n && rise_q < 6'h20) |-> (dev_oe == 4'h0);
    endproperty
    a_no_data_before_address: assert property (p_no_data_before_address)
        else $error("device drives before address complete");

    property p_dummy_byte;
        (!cs_n && cmd_q != `CMD_READ_SLOW && rise_q < 6'h28) |-> (dev_oe == 4'h0);
    endproperty
    a_dummy_byte: assert property (p_dummy_byte)
        else $error("device drives during dummy byte");

    property p_lanes_match_cmd;
        (!cs_n && dev_oe != 4'h0) |-> (dev_oe == lanes_exp);
    endproperty
    a_lanes_match_cmd: assert property (p_lanes_match_cmd)
        else $error("device drives wrong set of lines");

    property p_no_contention;
        dev_oe[0] |-> !host_oe[0];
    endproperty
    a_no_contention: assert property (p_no_contention)
        else $error("both ends drive serial input line");

    property p_change_after_fall;
        (!cs_n && !$past(cs_n) && dev_oe != 4'h0 && $changed(dev_out)) |-> fall_age_q < 4'h8;
    endproperty
    a_change_after_fall: assert property (p_change_after_fall)
        else $error("device data changed away from falling clock");

    property p_stable_while_high;
        (!cs_n && sck && $past(sck) && dev_oe != 4'h0) |-> $stable(dev_out);
    endproperty
    a_stable_while_high: assert property (p_stable_while_high)
        else $error("device data moved during high clock");

    property p_clock_still_outside;
        cs_n |-> !sck;
    endproperty
    a_clock_still_outside: assert property (p_clock_still_outside)
        else $error("serial clock moves outside frame");

    property p_host_single_line;
        (host_oe[3:1] == 3'h0) && (host_out[3:1] == 3'h0);
    endproperty
    a_host_single_line: assert property (p_host_single_line)
        else $error("host drives a line other than serial input");
endmodule

`default_nettype wire

// ==== dv/serial_flash_array_read_tb.sv ====
// Testbench: host and device joined by the link interface, reads of every kind.
// Assumes the package, header, interface and both design ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "serial_flash_regs.svh"

module serial_flash_array_read_tb
    import serial_flash_pkg::*;
;
    typedef struct packed {
        logic [7:0] c;
        logic [7:0] a;
        logic [7:0] n;
        logic q;
        logic [7:0] f;
    } row_s;
    localparam int N_ROWS = 6;
    // Command, address, byte count, quad enable, first byte expected
    row_s rows [N_ROWS] = '{
        '{8'h03, 8'h10, 8'h03, 1'b1, 8'hb5}, '{8'h0b, 8'hfe, 8'h04, 1'b1, 8'h5b},
        '{8'h3b, 8'hff, 8'h03, 1'b1, 8'h5a}, '{8'h6b, 8'hfd, 8'h05, 1'b1, 8'h58},
        '{8'h6b, 8'h20, 8'h02, 1'b0, 8'hff}, '{8'h0b, 8'h00, 8'h01, 1'b1, 8'ha5}};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic quad_en = 1'b1;
    logic mem_wr_en = 1'b0;
    logic [23:0] mem_wr_addr = 24'h0;
    logic [7:0] mem_wr_data = 8'h0;
    logic start = 1'b0;
    logic [7:0] cmd = 8'h0;
    logic [23:0] addr = 24'h0;
    logic [23:0] nbytes = 24'h0;
    logic busy;
    logic [7:0] rx_data;
    logic rx_valid;
    logic sck_prev = 1'b0;
    logic [31:0] wire_bits = 32'h0;
    logic [5:0] wire_cnt = 6'h0;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;

    spi_link_if link ();
    serial_flash_dev #(.ADDR_W(8)) i_serial_flash_dev (.clk(clk), .srst(srst), .link(link),
        .quad_enable_bit(quad_en), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(mem_wr_data));
    serial_flash_host i_serial_flash_host (.clk(clk), .srst(srst), .link(link), .start(start),
        .cmd(cmd), .addr(addr), .nbytes(nbytes), .busy(busy), .rx_data(rx_data),
        .rx_valid(rx_valid));
    serial_flash_sva i_serial_flash_sva (.clk(clk), .srst(srst), .cs_n(link.cs_n),
        .sck(link.sck), .io(link.io), .dev_out(link.dev_out), .dev_oe(link.dev_oe),
        .host_out(link.host_out), .host_oe(link.host_oe));

    // Clock generator, 40 ns period
    always #20 clk = ~clk;

    // Captures the first 32 bits seen on the serial input line of each frame
    always @(posedge clk) begin
        sck_prev <= link.sck;
        if (link.cs_n) begin
            wire_cnt <= 6'h00;
        end else if (link.sck && !sck_prev && wire_cnt < 6'h20) begin
            wire_bits <= {wire_bits[30:0], link.io[0]};
            wire_cnt <= wire_cnt + 6'h01;
        end
    end

    // Hang guard
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles >= 40000) begin
            n_mismatch = n_mismatch + 1;
            end_sim();
        end
    end

    function automatic logic [7:0] pat(input logic [7:0] a);
        return a ^ 8'ha5;
    endfunction

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bits(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic issue(input logic [7:0] c, input logic [7:0] a, input logic [7:0] n,
        input logic q);
        @(posedge clk);
        start <= 1'b1;
        cmd <= c;
        addr <= {16'h0, a};
        nbytes <= {16'h0, n};
        quad_en <= q;
        @(posedge clk);
        start <= 1'b0;
    endtask

    task automatic recv(input logic [7:0] a, input int n, input logic q, input logic [7:0] f);
        logic [7:0] exp;
        int w;
        for (int k = 0; k < n; k++) begin
            w = 0;
            do begin
                @(negedge clk);
                w++;
            end while (rx_valid !== 1'b1 && w < 3000);
            exp = (k == 0) ? f : (q ? pat(a + k[7:0]) : 8'hff);
            chk_bits({31'h0, rx_valid}, 32'h1);
            chk_byte(rx_data, exp);
        end
    endtask

    task automatic idle_wait();
        int w;
        w = 0;
        do begin
            @(negedge clk);
            w++;
        end while (busy !== 1'b0 && w < 3000);
        chk_bits({31'h0, busy}, 32'h0);
        repeat (8) @(negedge clk);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk_bits(32'({link.cs_n, link.sck, busy, rx_valid, link.dev_oe}), 32'h80);
        $display("reset test done");
        for (int i = 0; i < 256; i++) begin
            @(posedge clk);
            mem_wr_en <= 1'b1;
            mem_wr_addr <= i[23:0];
            mem_wr_data <= pat(i[7:0]);
        end
        @(posedge clk);
        mem_wr_en <= 1'b0;
        for (int r = 0; r < N_ROWS; r++) begin
            issue(rows[r].c, rows[r].a, rows[r].n, rows[r].q);
            recv(rows[r].a, int'(rows[r].n), rows[r].q, rows[r].f);
            idle_wait();
            chk_bits(wire_bits, {rows[r].c, 16'h0, rows[r].a});
            chk_bits({28'h0, link.io}, 32'hf);
            $display("row %0d done", r);
        end
        // Start while busy is ignored; the first read completes untouched
        issue(8'h03, 8'h40, 8'h02, 1'b1);
        repeat (50) @(posedge clk);
        issue(8'h6b, 8'h00, 8'h01, 1'b1);
        recv(8'h40, 2, 1'b1, pat(8'h40));
        idle_wait();
        repeat (20) @(negedge clk);
        chk_bits({31'h0, busy}, 32'h0);
        $display("refused start test done");
        // Reset in mid-stream of a dual read, then a quad read from idle roles
        issue(8'h3b, 8'h80, 8'h08, 1'b1);
        recv(8'h80, 1, 1'b1, pat(8'h80));
        @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(negedge clk);
        chk_bits({23'h0, link.cs_n, link.dev_oe, link.io}, 32'h10f);
        issue(8'h6b, 8'h30, 8'h02, 1'b1);
        recv(8'h30, 2, 1'b1, pat(8'h30));
        idle_wait();
        $display("mid-run reset test done");
        end_sim();
    end
endmodule

`default_nettype wire
